// File: shared/tmc_pkg.sv
package tmc_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MC_OSC_PERIODS = 12;
    localparam int unsigned MC_TIME_NS = MC_OSC_PERIODS * CLK_PERIOD_NS;
    localparam int unsigned MC_CLKS = MC_TIME_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_LOW0 = 8'h08;
    localparam logic [7:0] ADDR_HIGH0 = 8'h0C;
    localparam logic [7:0] ADDR_LOW1 = 8'h10;
    localparam logic [7:0] ADDR_HIGH1 = 8'h14;

    // ----------------------------------------
    // fields
    // ----------------------------------------
    localparam int unsigned MODE_TMR0_LSB = 0;
    localparam int unsigned MODE_TMR1_LSB = 4;
    localparam int unsigned FLD_GATE = 3;
    localparam int unsigned FLD_CT = 2;
    localparam int unsigned FLD_MODE_HIGH = 1;
    localparam int unsigned FLD_MODE_LOW = 0;
    localparam int unsigned CTL_RUN0 = 4;
    localparam int unsigned CTL_OVF0 = 5;
    localparam int unsigned CTL_RUN1 = 6;
    localparam int unsigned CTL_OVF1 = 7;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [1:0] FLAG_RST = 2'h0;

    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } tmc_mode_e;

    typedef enum logic [1:0] {
        APB_IDLE = 2'b01,
        APB_RESP = 2'b10
    } tmc_apb_e;

endpackage

// File: core/tmc_sync.sv
module tmc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_bad
        $error("tmc_sync: WIDTH must be at least 1");
    end

    // ----------------------------------------
    // two-stage synchroniser
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// File: core/tmc_edge.sv
module tmc_edge (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic pin_s,
    output logic fall_q
);
    logic smp_q;
    logic smp_d;
    logic fall_d;

    // ----------------------------------------
    // falling edge seen across two samples
    // ----------------------------------------
    always_comb begin
        smp_d = smp_q;
        fall_d = fall_q;
        if (tick) begin
            smp_d = pin_s;
            fall_d = smp_q & ~pin_s;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            smp_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            smp_q <= smp_d;
            fall_q <= fall_d;
        end
    end
endmodule

// File: core/tmc_timer_counters.sv
// Summary of operation
// - timer function counts once per machine cycle of twelve clocks.
// - counter function samples pin each machine cycle, counts high-then-low.
// - count from a detected fall shows in the following machine cycle.
// - edge recognition takes two machine cycles, so at most clk/24.
// - each timer has four modes from its own two-bit mode field.
// - mode 0 is 13-bit: high byte over low five bits of low byte.
// - rollover from all ones sets that timer's overflow flag, except timer 1 while timer 0 is split.
// - input counts only when run set and gate clear or irq pin high.
// - setting the run flag leaves the count unchanged.
// - mode 1 is a full 16-bit counter without prescaler.
// - mode 2 counts low byte, reloads it from high byte on overflow.
// - timer 0 mode 3 splits into two 8-bit counters.
// - split low byte uses all timer 0 controls and flag.
// - split high byte counts cycles, run by timer 1 run, sets flag 1.
// - during split, timer 1 stops in its own mode 3, else runs.
// - two independent 16-bit timer/counters, each timer or counter.
// - select bit clear picks machine cycles, set picks count pin.
// - mode and run flag changes apply only at machine cycle end; overflow flag writes apply at once.
// - timer 1 entering mode 3 stops its counting.
// - overflow flag set raises that timer's interrupt request.
module tmc_timer_counters #(
    parameter int unsigned MC_DIV = tmc_pkg::MC_CLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tmc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    output logic irq_timer_zero,
    output logic irq_timer_one
);
    import tmc_pkg::*;

    localparam int MCW = (MC_DIV > 1) ? $clog2(MC_DIV) : 1;

    if (MC_DIV < 2) begin : g_bad
        $error("tmc_timer_counters: MC_DIV must be at least 2");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [MCW-1:0] mc_cnt_q, mc_cnt_d;
    logic tick;
    logic [3:0] pins_s;
    logic [1:0] fall;
    logic [7:0] mode_q, mode_d, mode_act_q, mode_act_d;
    logic [1:0] run_q, run_d, run_act_q, run_act_d;
    logic [1:0] ovf_q, ovf_d, ovf_set;
    logic [1:0][7:0] low_q, low_d, high_q, high_d;
    logic [1:0] en;
    logic [16:0] step0, step1;
    logic [8:0] split_hi;
    tmc_mode_e md0, md1;
    tmc_apb_e apb_q, apb_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d, rd_data;
    logic rd_hit, wr_go;

    // ----------------------------------------
    // pins and machine cycle
    // ----------------------------------------
    tmc_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .din({ext_irq_pin_one, ext_irq_pin_zero,
              count_pin_one, count_pin_zero}),
        .dout(pins_s)
    );

    tmc_edge u_edge0 (
        .clk(pclk),
        .rst_n(presetn),
        .tick(tick),
        .pin_s(pins_s[0]),
        .fall_q(fall[0])
    );

    tmc_edge u_edge1 (
        .clk(pclk),
        .rst_n(presetn),
        .tick(tick),
        .pin_s(pins_s[1]),
        .fall_q(fall[1])
    );

    assign tick = (mc_cnt_q == MCW'(MC_DIV - 1));

    always_comb begin
        mc_cnt_d = tick ? '0 : MCW'(mc_cnt_q + 1'b1);
    end

    // ----------------------------------------
    // count step per mode
    // ----------------------------------------
    function automatic logic [16:0] tmc_step(input logic [1:0] m,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo);
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0] c8;
        c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        c16 = {1'b0, hi, lo} + 17'h00001;
        c8 = {1'b0, lo} + 9'h001;
        case (m)
            MODE_13BIT: tmc_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
            MODE_16BIT: tmc_step = c16;
            MODE_RELOAD: tmc_step = {c8[8], hi, c8[8] ? hi : c8[7:0]};
            default: tmc_step = {c8[8], hi, c8[7:0]};
        endcase
    endfunction

    assign md0 = tmc_mode_e'(mode_act_q[MODE_TMR0_LSB+:2]);
    assign md1 = tmc_mode_e'(mode_act_q[MODE_TMR1_LSB+:2]);
    assign step0 = tmc_step(md0, high_q[0], low_q[0]);
    assign step1 = tmc_step(md1, high_q[1], low_q[1]);
    assign split_hi = {1'b0, high_q[0]} + 9'h001;

    // ----------------------------------------
    // counters
    // ----------------------------------------
    always_comb begin
        // controls applied at machine cycle end
        mode_act_d = tick ? mode_q : mode_act_q;
        run_act_d = tick ? run_q : run_act_q;
        for (int i = 0; i < 2; i++) begin
            // select machine cycles or pin edge
            en[i] = tick & run_act_q[i]
                & (~mode_act_q[4*i+FLD_GATE] | pins_s[2+i])
                & (~mode_act_q[4*i+FLD_CT] | fall[i]);
        end
        low_d = low_q;
        high_d = high_q;
        ovf_set = 2'b00;
        if (md0 == MODE_SPLIT) begin
            // low byte on timer 0 controls
            if (en[0]) begin
                low_d[0] = step0[7:0];
                ovf_set[0] = step0[16];
            end
            // high byte on run one, flag one
            if (tick && run_act_q[1]) begin
                high_d[0] = split_hi[7:0];
                ovf_set[1] = split_hi[8];
            end
        end else if (en[0]) begin
            {high_d[0], low_d[0]} = step0[15:0];
            ovf_set[0] = step0[16];
        end
        // timer 1 runs unless in own mode 3
        if (md1 != MODE_SPLIT && en[1]) begin
            {high_d[1], low_d[1]} = step1[15:0];
            if (md0 != MODE_SPLIT) begin
                ovf_set[1] = step1[16];
            end
        end
        mode_d = mode_q;
        run_d = run_q;
        ovf_d = ovf_q;
        if (wr_go) begin
            case (paddr)
                ADDR_MODE: mode_d = pwdata[7:0];
                ADDR_CTRL: begin
                    run_d = {pwdata[CTL_RUN1], pwdata[CTL_RUN0]};
                    ovf_d = {pwdata[CTL_OVF1], pwdata[CTL_OVF0]};
                end
                ADDR_LOW0: low_d[0] = pwdata[7:0];
                ADDR_HIGH0: high_d[0] = pwdata[7:0];
                ADDR_LOW1: low_d[1] = pwdata[7:0];
                ADDR_HIGH1: high_d[1] = pwdata[7:0];
                default: ;
            endcase
        end
        ovf_d = ovf_d | ovf_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_cnt_q <= '0;
            mode_q <= MODE_RST;
            mode_act_q <= MODE_RST;
            run_q <= FLAG_RST;
            run_act_q <= FLAG_RST;
            ovf_q <= FLAG_RST;
            low_q <= {2{COUNT_RST}};
            high_q <= {2{COUNT_RST}};
        end else begin
            mc_cnt_q <= mc_cnt_d;
            mode_q <= mode_d;
            mode_act_q <= mode_act_d;
            run_q <= run_d;
            run_act_q <= run_act_d;
            ovf_q <= ovf_d;
            low_q <= low_d;
            high_q <= high_d;
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign wr_go = (apb_q == APB_RESP) & psel & penable & pwrite;

    always_comb begin
        rd_hit = 1'b1;
        rd_data = 32'h00000000;
        case (paddr)
            ADDR_MODE: rd_data[7:0] = mode_q;
            ADDR_CTRL: begin
                rd_data[CTL_RUN0] = run_q[0];
                rd_data[CTL_OVF0] = ovf_q[0];
                rd_data[CTL_RUN1] = run_q[1];
                rd_data[CTL_OVF1] = ovf_q[1];
            end
            ADDR_LOW0: rd_data[7:0] = low_q[0];
            ADDR_HIGH0: rd_data[7:0] = high_q[0];
            ADDR_LOW1: rd_data[7:0] = low_q[1];
            ADDR_HIGH1: rd_data[7:0] = high_q[1];
            default: rd_hit = 1'b0;
        endcase
        apb_d = apb_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        case (apb_q)
            APB_IDLE: begin
                if (psel && penable) begin
                    apb_d = APB_RESP;
                    pready_d = 1'b1;
                    pslverr_d = ~rd_hit;
                    prdata_d = pwrite ? 32'h00000000 : rd_data;
                end
            end
            APB_RESP: apb_d = APB_IDLE;
            default: apb_d = APB_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_q <= APB_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            apb_q <= apb_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq_timer_zero = ovf_q[0];
    assign irq_timer_one = ovf_q[1];

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_cnt16_tmr0;
        en[0] && md0 == MODE_16BIT && !wr_go;
    endsequence

    sequence s_edge_tmr0;
        tick && fall[0] && mode_act_q[FLD_CT];
    endsequence

    AST_MC_PERIOD: assert property (tick |-> ##MC_DIV tick)
        else $error("machine cycle tick spacing wrong");
    AST_MC_QUIET: assert property (tick |=> !tick && mc_cnt_q == '0)
        else $error("tick repeated inside a machine cycle");
    AST_NO_EDGE: assert property (
        mode_act_q[FLD_CT] && !fall[0] && md0 != MODE_SPLIT && !wr_go
        |=> $stable({high_q[0], low_q[0]}))
        else $error("counter moved without a pin fall");
    AST_EDGE_COUNT: assert property (
        s_edge_tmr0 and s_cnt16_tmr0
        |=> {high_q[0], low_q[0]} == $past({high_q[0], low_q[0]}) + 16'h0001)
        else $error("pin fall not counted next machine cycle");
    AST_MODE0_CARRY: assert property (
        en[0] && md0 == MODE_13BIT && low_q[0][4:0] == 5'h1F && !wr_go
        |=> high_q[0] == $past(high_q[0]) + 8'h01 && low_q[0][4:0] == 5'h00)
        else $error("13-bit prescaler carry wrong");
    AST_OVF_SET: assert property (
        s_cnt16_tmr0 and ({high_q[0], low_q[0]} == 16'hFFFF)
        |=> ovf_q[0] && irq_timer_zero)
        else $error("overflow flag zero not set");
    AST_RUN_HOLD: assert property (
        !run_act_q[0] && md0 != MODE_SPLIT && !wr_go
        |=> $stable({high_q[0], low_q[0]}))
        else $error("timer zero moved while stopped");
    AST_RELOAD: assert property (
        en[0] && md0 == MODE_RELOAD && low_q[0] == 8'hFF && !wr_go
        |=> low_q[0] == $past(high_q[0]) && $stable(high_q[0]) && ovf_q[0])
        else $error("auto reload wrong");
    AST_SPLIT_HI: assert property (
        tick && md0 == MODE_SPLIT && run_act_q[1] && high_q[0] == 8'hFF
        && !wr_go |=> ovf_q[1] && high_q[0] == 8'h00)
        else $error("split high byte overflow did not set flag one");
    AST_TMR1_STOP: assert property (
        md1 == MODE_SPLIT && !wr_go |=> $stable({high_q[1], low_q[1]}))
        else $error("timer one counted in its own mode 3");
    AST_ACT_SYNC: assert property (
        !tick |=> $stable(mode_act_q) && $stable(run_act_q))
        else $error("control change applied off machine cycle end");
endmodule

// File: tb/tmc_pins_model.sv
module tmc_pins_model #(
    parameter int unsigned MC = 4
) (
    input wire logic pclk,
    input wire logic go,
    input wire logic [3:0] pulses,
    input wire logic gate_lvl,
    output logic count_pin_zero,
    output logic count_pin_one,
    output logic ext_irq_pin_zero,
    output logic ext_irq_pin_one
);
    timeunit 1ns;
    timeprecision 1ps;

    assign ext_irq_pin_zero = gate_lvl;
    assign ext_irq_pin_one = gate_lvl;

    initial begin
        count_pin_zero = 1'b1;
        count_pin_one = 1'b1;
        forever begin
            @(posedge pclk);
            if (go) begin
                repeat (pulses) begin
                    repeat (2 * MC) @(posedge pclk);
                    count_pin_zero <= 1'b0;
                    count_pin_one <= 1'b0;
                    repeat (2 * MC) @(posedge pclk);
                    count_pin_zero <= 1'b1;
                    count_pin_one <= 1'b1;
                end
            end
        end
    end
endmodule

// File: tb/dual_timer_event_counter_tb.sv
module dual_timer_event_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tmc_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int unsigned MC = 4;
    // ticks land on edges where cycles % MC == TICK_PH (reset lifts there)
    localparam int unsigned TICK_PH = 2;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic err;
    } tmc_exp_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic go, gate_lvl, cpz, cpo, eiz, eio, irq0, irq1;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [3:0] pulses;
    tmc_exp_s exp_q[$];
    tmc_exp_s e;
    int fails, checks, cycles;
    integer seed;

    tmc_timer_counters #(.MC_DIV(MC)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_pin_zero(cpz),
        .count_pin_one(cpo), .ext_irq_pin_zero(eiz), .ext_irq_pin_one(eio),
        .irq_timer_zero(irq0), .irq_timer_one(irq1)
    );

    tmc_pins_model #(.MC(MC)) u_pins (
        .pclk(pclk), .go(go), .pulses(pulses), .gate_lvl(gate_lvl),
        .count_pin_zero(cpz), .count_pin_one(cpo),
        .ext_irq_pin_zero(eiz), .ext_irq_pin_one(eio)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ----------------------------------------
    // checking
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp_bit(input string name, input logic ex, input logic s);
        checks++;
        if (s !== ex) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", name, ex, s);
        end
    endtask

    task automatic cmp_read(input tmc_exp_s x);
        checks++;
        if ((prdata & x.mask) !== x.data || pslverr !== x.err) begin
            fails++;
            $display("[FAIL] read %h expected %h/%b seen %h/%b", paddr,
                x.data, x.err, prdata & x.mask, pslverr);
        end
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fails++;
            give_verdict();
        end
    end

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("[FAIL] read %h expected none seen %h", paddr, prdata);
            end else begin
                e = exp_q.pop_front();
                cmp_read(e);
            end
        end
    end

    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the slave; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle cycle keeps each strobe to one change per edge
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
            input logic [7:0] m, input logic err);
        exp_q.push_back('{d, {24'hFFFFFF, m}, err});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic run_case(input logic [7:0] mode, run, mid,
            input int k, input logic [3:0] np,
            input logic [31:0] pre, post);
        logic [7:0] m;
        m = (mode[1:0] == MODE_13BIT) ? 8'h1F : 8'hFF;
        apb(1'b1, ADDR_MODE, {24'h0, mode});
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_LOW0, {24'h0, pre[7:0]});
        apb(1'b1, ADDR_HIGH0, {24'h0, pre[15:8]});
        apb(1'b1, ADDR_LOW1, {24'h0, pre[23:16]});
        apb(1'b1, ADDR_HIGH1, {24'h0, pre[31:24]});
        // run goes live on the tick just after the write lands
        while ((cycles + 4) % MC != TICK_PH) @(posedge pclk);
        apb(1'b1, ADDR_CTRL, {24'h0, run});
        pulses <= np;
        go <= (np != 4'h0);
        @(posedge pclk);
        go <= 1'b0;
        // stop write then lands so that exactly k ticks count
        repeat (k * MC - 9) @(posedge pclk);
        rd(ADDR_CTRL, {24'h0, mid}, 8'hFF, 1'b0);
        cmp_bit("irq0", mid[CTL_OVF0], irq0);
        cmp_bit("irq1", mid[CTL_OVF1], irq1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        rd(ADDR_LOW0, {24'h0, post[7:0] & m}, m, 1'b0);
        rd(ADDR_HIGH0, {24'h0, post[15:8]}, 8'hFF, 1'b0);
        rd(ADDR_LOW1, {24'h0, post[23:16]}, 8'hFF, 1'b0);
        rd(ADDR_HIGH1, {24'h0, post[31:24]}, 8'hFF, 1'b0);
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        seed = 32'h6613;
        {psel, penable, pwrite, go, gate_lvl} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        pulses = 4'h0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), 32'h0, 8'hFF, 1'b0);
        end
        rd(8'h18, 32'h0, 8'hFF, 1'b1);
        apb(1'b1, 8'h18, 32'hFF);
        apb(1'b1, ADDR_CTRL, 32'h0F);
        rd(ADDR_CTRL, 32'h0, 8'hFF, 1'b0);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            apb(1'b1, ADDR_HIGH1, v);
            rd(ADDR_HIGH1, {24'h0, v[7:0]}, 8'hFF, 1'b0);
        end
        run_case(8'h01, 8'h10, 8'h30, 6, 4'h0, 32'hAA55FFFE,
            32'hAA550004);
        run_case(8'h00, 8'h10, 8'h30, 4, 4'h0, 32'hAA55FF1E,
            32'hAA550002);
        run_case(8'h02, 8'h10, 8'h30, 4, 4'h0, 32'h000080FE,
            32'h00008082);
        run_case(8'h3B, 8'h40, 8'hC0, 4, 4'h0, 32'h3322FE11,
            32'h33220211);
        run_case(8'h13, 8'h50, 8'h70, 4, 4'h0, 32'hFFFE10FE,
            32'h00021402);
        for (int g = 0; g < 2; g++) begin
            gate_lvl <= g[0];
            run_case(8'h09, 8'h10, 8'h10, 4, 4'h0, 32'h0,
                g[0] ? 32'h4 : 32'h0);
        end
        run_case(8'h55, 8'h50, 8'h50, 20, 4'h3, 32'h0,
            32'h00030003);
        give_verdict();
    end
endmodule
